// ===== core/fpx_consts.vh
// Constants for the floating-point exception unit
`ifndef FPX_CONSTS_VH
`define FPX_CONSTS_VH
// Register offsets (byte addresses, one word each)
`define FPX_ADDR_STATUS 4'h0
`define FPX_ADDR_CONTROL 4'h4
`define FPX_ADDR_SYSCTL 4'h8
`define FPX_ADDR_TRAP 4'hC
// Status word fields
`define FPX_SW_OVF 3
`define FPX_SW_UNF 4
`define FPX_SW_INX 5
`define FPX_SW_ESUM 7
`define FPX_SW_C1 9
// Control word fields
`define FPX_CW_OVM 3
`define FPX_CW_UNM 4
`define FPX_CW_INM 5
// System control field
`define FPX_CR_NE 5
// Reset values
`define FPX_SW_RESET 16'h0000
`define FPX_CW_RESET 16'h037F
`define FPX_CR_RESET 32'h0000_0000
// Trap vector
`define FPX_TRAP_VECTOR 8'h10
// Instruction classes
`define FPX_OP_NONE 4'h0
`define FPX_OP_ARITH 4'h1
`define FPX_OP_TRANS 4'h2
`define FPX_OP_STORE 4'h3
`define FPX_OP_BARRIER 4'h4
`define FPX_OP_SIMD 4'h5
`define FPX_OP_INIT_NW 4'h6
`define FPX_OP_CLEX_NW 4'h7
`define FPX_OP_STSW_NW 4'h8
`define FPX_OP_STCW_NW 4'h9
`define FPX_OP_STENV_NW 4'hA
`define FPX_OP_SAVE_NW 4'hB
`endif

// ===== core/fpx_exc_unit.v
// Floating-point inexact exception and deferred trap synchroniser
`include "fpx_consts.vh"

// Overview of operation
// - Inexact result raises the precision flag.
// - Transcendental operations always count as inexact.
// - Inexact flag is status bit 5, its mask control bit 5.
// - Masked inexact alone: round-up indicator shows whether result rounded up.
// - Unmasked inexact alone: same actions plus the handler becomes pending.
// - With masked overflow/underflow: both flags set; handler only if inexact unmasked.
// - With unmasked overflow/underflow to register: flags set, handler pending.
// - Unmasked overflow/underflow to memory: no inexact flag, round-up cleared.
// - Masked exceptions need no deferred trap.
// - Unmasked exception aborts the instruction and is recorded as pending.
// - Next waiting instruction or barrier checks summary and traps first.
// - Non-waiting instructions run without checking pending exceptions.
// - Init, clear, store-env and save discard pending exceptions.
// - Status and control stores leave both words, so exception stays pending.
// - System control bit 5 set selects native delivery.
// - Native mode sets individual flag and the summary flag.
// - Native trap vector 16 before next waiting, barrier or packed-SIMD instruction.
// - Non-waiting next instruction runs untrapped; exception stays pending except after init, clear, store-env or save.
// - Overflow flag/mask at bit 3, underflow at bit 4.
// - Native select clear uses external error pin signalling.
module fpx_exc_unit (
    input wire clk_sys,
    input wire rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg avs_response_err,
    input wire issue_valid,
    input wire [3:0] issue_class,
    input wire res_inexact,
    input wire res_round_up,
    input wire res_overflow,
    input wire res_underflow,
    input wire res_mem_dest,
    output reg issue_ready,
    output reg issue_done,
    output reg issue_abort,
    output reg trap_valid,
    output reg [7:0] trap_vector,
    output reg fp_error_pin
);

reg [15:0] status_word;
reg [15:0] control_word;
reg [31:0] sys_ctrl;
reg [15:0] next_status;
reg [15:0] next_control;
reg pending_trap;
reg is_fp;
reg is_waiting;
reg discards;
reg eff_inexact;
reg unm_ovf;
reg unm_unf;
reg unm_inx;
reg do_trap;
reg bus_phase;
reg [31:0] next_rdata;
reg addr_ok;
wire native_mode;
wire [15:0] unmasked_set;

assign native_mode = sys_ctrl[`FPX_CR_NE];
assign unmasked_set = status_word & ~control_word;

// Classify the issued instruction
always @* begin
    is_fp = 1'b0;
    is_waiting = 1'b0;
    discards = 1'b0;
    case (issue_class)
        `FPX_OP_ARITH, `FPX_OP_TRANS, `FPX_OP_STORE: begin
            is_fp = 1'b1;
            is_waiting = 1'b1;
        end
        `FPX_OP_BARRIER, `FPX_OP_SIMD: begin
            is_waiting = 1'b1;
        end
        `FPX_OP_INIT_NW, `FPX_OP_CLEX_NW, `FPX_OP_STENV_NW, `FPX_OP_SAVE_NW: begin
            discards = 1'b1;
        end
        default: begin
            is_fp = 1'b0;
        end
    endcase
end

// Exception evaluation of one operation
always @* begin
    next_status = status_word;
    next_control = control_word;
    eff_inexact = res_inexact | (issue_class == `FPX_OP_TRANS);
    unm_ovf = res_overflow & ~control_word[`FPX_CW_OVM];
    unm_unf = res_underflow & ~control_word[`FPX_CW_UNM];
    unm_inx = 1'b0;
    do_trap = issue_valid & issue_ready & is_waiting & pending_trap;
    if (issue_valid && issue_ready && !do_trap) begin
        if (is_fp) begin
            if ((unm_ovf || unm_unf) && res_mem_dest) begin
                next_status[`FPX_SW_C1] = 1'b0;
            end else if (eff_inexact) begin
                next_status[`FPX_SW_INX] = 1'b1;
                next_status[`FPX_SW_C1] = res_round_up;
                unm_inx = ~control_word[`FPX_CW_INM];
            end
            if (res_overflow) begin
                next_status[`FPX_SW_OVF] = 1'b1;
            end
            if (res_underflow) begin
                next_status[`FPX_SW_UNF] = 1'b1;
            end
        end
        if (issue_class == `FPX_OP_INIT_NW) begin
            next_status = `FPX_SW_RESET;
            next_control = `FPX_CW_RESET;
        end else if (discards) begin
            next_status[`FPX_SW_ESUM:0] = 8'h00;
        end
        // status and control stores change nothing
    end
    next_status[`FPX_SW_ESUM] = |(next_status[5:0] & ~next_control[5:0]);
end

// Instruction side and status state
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        status_word <= `FPX_SW_RESET;
        control_word <= `FPX_CW_RESET;
        pending_trap <= 1'b0;
        issue_ready <= 1'b0;
        issue_done <= 1'b0;
        issue_abort <= 1'b0;
        trap_valid <= 1'b0;
        trap_vector <= 8'h00;
        fp_error_pin <= 1'b0;
    end else begin
        issue_ready <= 1'b1;
        issue_done <= 1'b0;
        issue_abort <= 1'b0;
        trap_valid <= 1'b0;
        // Hardware updates always land; a bus write then overrides only its own byte
        status_word <= next_status;
        control_word <= next_control;
        if (avs_write && !avs_waitrequest && avs_address == `FPX_ADDR_CONTROL && avs_byteenable[0]) begin
            control_word[7:0] <= avs_writedata[7:0];
        end
        // A flag raised in the cycle of a status write survives the write
        if (avs_write && !avs_waitrequest && avs_address == `FPX_ADDR_STATUS) begin
            status_word[7:0] <= (avs_writedata[7:0] | (next_status[7:0] & ~status_word[7:0])) & 8'h3F;
        end
        if (do_trap) begin
            trap_valid <= native_mode;
            trap_vector <= `FPX_TRAP_VECTOR;
            fp_error_pin <= ~native_mode;
        end else if (issue_valid && issue_ready) begin
            issue_abort <= is_fp & (unm_ovf | unm_unf | unm_inx);
            issue_done <= 1'b1;
        end
        pending_trap <= next_status[`FPX_SW_ESUM];
        if (!next_status[`FPX_SW_ESUM]) begin
            fp_error_pin <= 1'b0;
        end
    end
end

// Register read mux
always @* begin
    addr_ok = 1'b1;
    next_rdata = 32'h0000_0000;
    case (avs_address)
        `FPX_ADDR_STATUS: next_rdata = {16'h0000, status_word};
        `FPX_ADDR_CONTROL: next_rdata = {16'h0000, control_word};
        `FPX_ADDR_SYSCTL: next_rdata = sys_ctrl;
        `FPX_ADDR_TRAP: next_rdata = {23'h00_0000, pending_trap, trap_vector};
        default: addr_ok = 1'b0;
    endcase
end

// Avalon slave: one wait cycle per access
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        sys_ctrl <= `FPX_CR_RESET;
        avs_readdata <= 32'h0000_0000;
        avs_waitrequest <= 1'b1;
        avs_response_err <= 1'b0;
        bus_phase <= 1'b0;
    end else begin
        avs_waitrequest <= 1'b1;
        if ((avs_read || avs_write) && !bus_phase) begin
            bus_phase <= 1'b1;
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? next_rdata : 32'h0000_0000;
            avs_response_err <= ~addr_ok;
        end else begin
            bus_phase <= 1'b0;
        end
        if (avs_write && !avs_waitrequest && avs_address == `FPX_ADDR_SYSCTL && avs_byteenable[0]) begin
            sys_ctrl[7:0] <= avs_writedata[7:0];
        end
    end
end

endmodule // fpx_exc_unit

// ===== testbench/fpx_exc_chk.sv
// Port checker for the exception unit
`include "fpx_consts.vh"
module fpx_exc_chk (
    input wire clk_sys,
    input wire rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire avs_response_err,
    input wire issue_valid,
    input wire [3:0] issue_class,
    input wire issue_ready,
    input wire issue_done,
    input wire issue_abort,
    input wire trap_valid,
    input wire [7:0] trap_vector,
    input wire fp_error_pin
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_taken;
        issue_valid && issue_ready;
    endsequence
    sequence s_nowait;
        s_taken ##0 issue_class >= `FPX_OP_INIT_NW && issue_class <= `FPX_OP_SAVE_NW;
    endsequence
    a_issue_answer: assert property (s_taken |=> issue_done || trap_valid || fp_error_pin)
        else $error("issue not answered");
    a_trap_pin_excl: assert property (trap_valid |-> !fp_error_pin)
        else $error("vector trap with error pin");
    a_no_spurious: assert property (!(issue_valid && issue_ready) |=> !issue_done && !trap_valid)
        else $error("answer without issue");
    a_abort_with_done: assert property (issue_abort |-> issue_done)
        else $error("abort without done");
    a_trap_not_done: assert property (trap_valid |-> !issue_done)
        else $error("trapped instruction executed");
    a_trap_vector: assert property (trap_valid |-> trap_vector == `FPX_TRAP_VECTOR)
        else $error("wrong trap vector");
    a_nowait_untrapped: assert property (s_nowait |=> issue_done && !trap_valid)
        else $error("non-waiting instruction trapped");
    a_bus_answer: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
        else $error("bus answer late");
    a_err_unmapped: assert property ((avs_read || avs_write) && !avs_waitrequest
        |-> avs_response_err == (avs_address[1:0] != 2'b00))
        else $error("wrong error response");
endmodule // fpx_exc_chk
bind fpx_exc_unit fpx_exc_chk i_fpx_exc_chk (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
    .avs_waitrequest, .avs_response_err, .issue_valid, .issue_class, .issue_ready, .issue_done,
    .issue_abort, .trap_valid, .trap_vector, .fp_error_pin);

// ===== testbench/fpx_issue_model.sv
// Instruction issue model standing in for the integer pipeline
module fpx_issue_model (
    input wire clk_sys,
    input wire issue_ready,
    output logic issue_valid,
    output logic [3:0] issue_class,
    output logic [4:0] res
);
    initial begin
        issue_valid = 1'b0;
        issue_class = 4'h0;
        res = 5'h00;
    end
    // Attributes are inverted once released, so stale values never look valid
    task automatic send(input logic [3:0] cls, input logic [4:0] r);
        issue_valid <= 1'b1;
        issue_class <= cls;
        res <= r;
        @(posedge clk_sys);
        while (issue_ready !== 1'b1) @(posedge clk_sys);
        issue_valid <= 1'b0;
        issue_class <= ~cls;
        res <= ~r;
        @(posedge clk_sys);
    endtask
endmodule // fpx_issue_model

// ===== testbench/fpx_exc_unit_tb.sv
// Self-checking bench for the exception unit
`include "fpx_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module fpx_exc_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, avs_response_err, issue_valid;
    logic issue_ready, issue_done, issue_abort, trap_valid, fp_error_pin, ru;
    logic [3:0] avs_address, issue_class;
    logic [4:0] res;
    logic [7:0] trap_vector;
    logic [31:0] avs_writedata, avs_readdata, got;
    logic [31:0] exp_q[$];
    int checks = 0;
    int miscompares = 0;
    fpx_exc_unit i_fpx_exc_unit (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err),
        .issue_valid(issue_valid), .issue_class(issue_class), .res_inexact(res[4]), .res_round_up(res[3]),
        .res_overflow(res[2]), .res_underflow(res[1]), .res_mem_dest(res[0]), .issue_ready(issue_ready),
        .issue_done(issue_done), .issue_abort(issue_abort), .trap_valid(trap_valid),
        .trap_vector(trap_vector), .fp_error_pin(fp_error_pin));
    fpx_issue_model i_fpx_issue_model (.clk_sys(clk_sys), .issue_ready(issue_ready),
        .issue_valid(issue_valid), .issue_class(issue_class), .res(res));
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task automatic iss(input logic [3:0] c, input logic [4:0] r, input logic [1:0] e);
        exp_q.push_back({30'h0, e});
        i_fpx_issue_model.send(c, r);
    endtask
    task automatic final_report();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (checks > 0 && miscompares == 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Read data and issue answers both land in the one ordered queue
    always @(posedge clk_sys) begin
        if (!rst && ((avs_read && avs_waitrequest === 1'b0) || issue_done || trap_valid)) begin
            got = avs_read ? avs_readdata : {30'h0, trap_valid, issue_abort};
            if (exp_q.size() == 0) `CHK(got, 32'hdead_beef)
            else `CHK(got, exp_q.pop_front())
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #20000;
        miscompares++;
        final_report();
    end
    initial begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0000_0000;
        void'($urandom(7826));
        ru = 1'($urandom);
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(`FPX_ADDR_STATUS, 32'h0000_0000);
        rd(`FPX_ADDR_CONTROL, 32'h0000_037F);
        rd(`FPX_ADDR_SYSCTL, 32'h0000_0000);
        rd(4'h2, 32'h0000_0000);
        iss(`FPX_OP_TRANS, {1'b0, ru, 3'b000}, 2'b00);
        rd(`FPX_ADDR_STATUS, {22'h0, ru, 9'h020});
        wr_all();
        iss(`FPX_OP_ARITH, 5'b11000, 2'b01);
        rd(`FPX_ADDR_STATUS, 32'h0000_02A0);
        iss(`FPX_OP_STSW_NW, 5'b00000, 2'b00);
        rd(`FPX_ADDR_STATUS, 32'h0000_02A0);
        iss(`FPX_OP_SIMD, 5'b00000, 2'b10);
        iss(`FPX_OP_BARRIER, 5'b00000, 2'b10);
        rd(`FPX_ADDR_TRAP, 32'h0000_0110);
        iss(`FPX_OP_CLEX_NW, 5'b00000, 2'b00);
        iss(`FPX_OP_ARITH, 5'b00000, 2'b00);
        bus(1'b1, `FPX_ADDR_CONTROL, 32'h0000_0017);
        iss(`FPX_OP_STORE, 5'b11101, 2'b01);
        iss(`FPX_OP_BARRIER, 5'b00000, 2'b10);
        rd(`FPX_ADDR_STATUS, 32'h0000_0088);
        iss(`FPX_OP_INIT_NW, 5'b00000, 2'b00);
        rd(`FPX_ADDR_STATUS, 32'h0000_0000);
        bus(1'b1, `FPX_ADDR_SYSCTL, 32'h0000_0000);
        bus(1'b1, `FPX_ADDR_CONTROL, 32'h0000_001F);
        iss(`FPX_OP_ARITH, 5'b10000, 2'b01);
        // Compatibility mode takes the waiting instruction with issue_ready held high but never answers it: no done, no trap, only the pin
        i_fpx_issue_model.send(`FPX_OP_BARRIER, 5'b00000);
        `CHK(fp_error_pin, 1'b1)
        final_report();
    end
    // Native delivery, inexact unmasked, status low byte cleared
    task automatic wr_all();
        bus(1'b1, `FPX_ADDR_SYSCTL, 32'h0000_0020);
        rd(`FPX_ADDR_SYSCTL, 32'h0000_0020);
        bus(1'b1, `FPX_ADDR_CONTROL, 32'h0000_001F);
        rd(`FPX_ADDR_CONTROL, 32'h0000_031F);
        bus(1'b1, `FPX_ADDR_STATUS, 32'h0000_0000);
    endtask
endmodule // fpx_exc_unit_tb
